// ==== bur_defs.svh ====
// constants of the four stage bidirectional universal shift register
`ifndef BUR_DEFS_SVH
`define BUR_DEFS_SVH

// ****************************************************************
// widths and depths
// ****************************************************************
`define BUR_STAGES        4
`define BUR_FIFO_DEPTH    32

// ****************************************************************
// mode select codes, {mode_select_high, mode_select_low}
// ****************************************************************
`define BUR_MODE_HOLD     2'h0
`define BUR_MODE_RIGHT    2'h1
`define BUR_MODE_LEFT     2'h2
`define BUR_MODE_LOAD     2'h3

// ****************************************************************
// reset values
// ****************************************************************
`define BUR_STAGE_RST     4'h0
`define BUR_FLAG_RST      1'h0

`endif

// ==== bur_pkg.sv ====
// types shared by the shift register files
package bur_pkg;
    typedef enum logic [1:0] {
        BUR_OP_HOLD,
        BUR_OP_RIGHT,
        BUR_OP_LEFT,
        BUR_OP_LOAD
    } bur_op_type;
endpackage

// ==== bur_fifo.sv ====
// snapshot fifo with a registered output word
`timescale 1ns/1ps
`default_nettype none
`include "bur_defs.svh"

module bur_fifo
    import bur_pkg::*;
#(
    parameter int WIDTH = `BUR_STAGES,
    parameter int DEPTH = `BUR_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    // pointers wrap by overflow, so only powers of two are served
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
            $error("bur_fifo: DEPTH must be a power of two and WIDTH positive");
        end
    endgenerate

    // ****************************************************************
    // storage and pointers
    // ****************************************************************
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    wr_ptr_nxt;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW-1:0]    rd_ptr_nxt;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             dv_r;
    logic             dv_nxt;
    logic [WIDTH-1:0] dout_r;
    logic [WIDTH-1:0] dout_nxt;
    logic             push;
    logic             load;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = dv_r;
    assign out_data  = dout_r;

    always_comb begin
        push       = in_valid && in_ready;
        // refill the output word when it is empty or leaving this cycle
        load       = (count_r != '0) && (!dv_r || out_ready);
        wr_ptr_nxt = push ? wr_ptr_r + AW'(1) : wr_ptr_r;
        rd_ptr_nxt = load ? rd_ptr_r + AW'(1) : rd_ptr_r;
        count_nxt  = count_r + (AW+1)'(push) - (AW+1)'(load);
        dv_nxt     = dv_r;
        dout_nxt   = dout_r;
        if (load) begin
            dv_nxt   = 1'b1;
            dout_nxt = mem_r[rd_ptr_r];
        end else if (out_ready) begin
            dv_nxt   = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            dv_r     <= `BUR_FLAG_RST;
            dout_r   <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
            dv_r     <= dv_nxt;
            dout_r   <= dout_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== bur_shift_reg4.sv ====
// four stage bidirectional universal shift register with snapshot stream
// How it works
// [RQ1] four flip-flops hold the state; shifts and loads act on the rising clock edge; here a full snapshot fifo holds them off
// [RQ2] both mode selects low keeps all four stages unchanged
// [RQ3] both mode selects high copies the parallel inputs into the stages on the edge
// [RQ4] high select only: stages move toward the first, left serial enters last
// [RQ5] low select only: stages move toward the last, right serial enters first
// [RQ6] clear_n low forces all stage outputs low at once, overriding everything
// [RQ7] without a clock edge and with clear inactive, stages keep their levels
// [RQ8] the driver keeps inputs stable around edges and releases clear synchronously
`timescale 1ns/1ps
`default_nettype none
`include "bur_defs.svh"

module bur_shift_reg4
    import bur_pkg::*;
#(
    parameter int STAGES     = `BUR_STAGES,
    parameter int FIFO_DEPTH = `BUR_FIFO_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              clear_n,
    input  wire logic              mode_select_low,
    input  wire logic              mode_select_high,
    input  wire logic              serial_left_in,
    input  wire logic              serial_right_in,
    input  wire logic [STAGES-1:0] parallel_in,
    output logic      [STAGES-1:0] stage_outputs,
    output logic                   first_stage_out,
    output logic                   last_stage_out,
    output logic                   op_ready,
    output logic                   snap_valid,
    input  wire logic              snap_ready,
    output logic      [STAGES-1:0] snap_data
);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    generate
        if (STAGES < 2) begin : g_bad
            $error("bur_shift_reg4: STAGES must be at least two");
        end
    endgenerate

    // ****************************************************************
    // mode decode
    // ****************************************************************
    bur_op_type        op;
    logic              fifo_in_ready;
    logic              stall;
    logic              upd;
    logic [STAGES-1:0] op_val;
    logic [STAGES-1:0] stage_r;
    logic [STAGES-1:0] stage_nxt;

    always_comb begin
        unique case ({mode_select_high, mode_select_low})
            `BUR_MODE_HOLD:  op = BUR_OP_HOLD;
            `BUR_MODE_RIGHT: op = BUR_OP_RIGHT;
            `BUR_MODE_LEFT:  op = BUR_OP_LEFT;
            `BUR_MODE_LOAD:  op = BUR_OP_LOAD;
        endcase
    end

    // ****************************************************************
    // stage register
    // ****************************************************************
    // a full snapshot fifo stalls shifts and loads; clear is never stalled
    assign stall = (op != BUR_OP_HOLD) && !fifo_in_ready;
    assign upd   = !clear_n || ((op != BUR_OP_HOLD) && fifo_in_ready);

    always_comb begin
        unique case (op)
            BUR_OP_HOLD:  op_val = stage_r;                                   // [RQ2]
            BUR_OP_RIGHT: op_val = {stage_r[STAGES-2:0], serial_right_in};    // [RQ5]
            BUR_OP_LEFT:  op_val = {serial_left_in, stage_r[STAGES-1:1]};     // [RQ4]
            BUR_OP_LOAD:  op_val = parallel_in;                               // [RQ3]
        endcase
        if (!clear_n) begin
            stage_nxt = '0;                                                   // [RQ6]
        end else if (stall) begin
            stage_nxt = stage_r;                                              // [RQ7]
        end else begin
            stage_nxt = op_val;                                               // [RQ1]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stage_r <= '0;
        end else begin
            stage_r <= stage_nxt;                                             // [RQ1]
        end
    end

    // clear acts on the outputs without waiting for an edge
    assign stage_outputs   = clear_n ? stage_r : '0;                          // [RQ6]
    assign first_stage_out = stage_outputs[0];
    assign last_stage_out  = stage_outputs[STAGES-1];
    assign op_ready        = fifo_in_ready;

    // ****************************************************************
    // snapshot stream
    // ****************************************************************
    // every shift or load offers its new state; holds and clears do not
    bur_fifo #(
        .WIDTH (STAGES),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (clear_n && (op != BUR_OP_HOLD)),
        .in_ready  (fifo_in_ready),
        .in_data   (op_val),
        .out_valid (snap_valid),
        .out_ready (snap_ready),
        .out_data  (snap_data)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [STAGES-1:0] prev_stage_r;
    logic              prev_ok_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            prev_stage_r <= '0;
            prev_ok_r    <= 1'b0;
        end else begin
            prev_stage_r <= stage_r;
            prev_ok_r    <= clear_n && fifo_in_ready;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_clear_out_low: assert property ( // [RQ6]
        !clear_n |-> (stage_outputs == '0) && !first_stage_out && !last_stage_out)
        else $error("stage outputs not low while clear is low");

    a_clear_state_zero: assert property ( // [RQ6]
        !clear_n |=> (stage_r == '0))
        else $error("stage state not zero after clear");

    a_hold_keeps: assert property ( // [RQ2]
        (clear_n && op == BUR_OP_HOLD) [*2] |=> (stage_r == prev_stage_r) && $stable(stage_r))
        else $error("stages changed during hold");

    a_load_copies: assert property ( // [RQ3]
        (clear_n && op == BUR_OP_LOAD && op_ready) |=> (stage_r == $past(parallel_in)))
        else $error("parallel load did not copy inputs");

    a_shift_right: assert property ( // [RQ5]
        (clear_n && op == BUR_OP_RIGHT && op_ready) |=>
            (stage_r[0] == $past(serial_right_in)) &&
            (stage_r[STAGES-1:1] == prev_stage_r[STAGES-2:0]) && prev_ok_r)
        else $error("right shift moved stages wrongly");

    a_shift_left: assert property ( // [RQ4]
        (clear_n && op == BUR_OP_LEFT && op_ready) |=>
            (stage_r[STAGES-1] == $past(serial_left_in)) &&
            (stage_r[STAGES-2:0] == prev_stage_r[STAGES-1:1]))
        else $error("left shift moved stages wrongly");

    a_stall_keeps: assert property ( // [RQ7]
        (clear_n && !op_ready) |=> $stable(stage_r))
        else $error("stages changed while stalled");

    a_change_cause: assert property ( // [RQ1]
        !$stable(stage_r) |-> $past(upd))
        else $error("stages changed without clear, shift or load");

    a_snap_steady: assert property (
        (snap_valid && !snap_ready) |=> snap_valid && $stable(snap_data))
        else $error("snapshot word dropped while stalled");

    c_right_then_left: cover property (
        (clear_n && op == BUR_OP_RIGHT && op_ready) ##1 (clear_n && op == BUR_OP_LEFT && op_ready));
    c_load_then_clear: cover property (
        (clear_n && op == BUR_OP_LOAD && op_ready) ##1 (!clear_n));
    c_fifo_stall: cover property (
        (clear_n && op != BUR_OP_HOLD && !op_ready) [*2]);
    c_snap_drain: cover property (
        (snap_valid && snap_ready) ##1 (snap_valid && snap_ready));

endmodule
`default_nettype wire

// ==== bur_snap_sink.sv ====
// consumer model on the far side of the snapshot stream
`timescale 1ns/1ps
`default_nettype none

module bur_snap_sink (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       stall,
    input  wire logic       snap_valid,
    input  wire logic [3:0] snap_data,
    output logic            snap_ready,
    output logic      [7:0] taken_cnt,
    output logic      [3:0] last_word
);
    // stalls only when the bench asks, to fill the fifo
    assign snap_ready = !stall;

    always_ff @(posedge clk) begin
        if (srst) begin
            taken_cnt <= 8'h00;
            last_word <= 4'h0;
        end else if (snap_valid && snap_ready) begin
            taken_cnt <= taken_cnt + 8'h01;
            last_word <= snap_data;
        end
    end
endmodule
`default_nettype wire

// ==== bidir_universal_shift_reg4_test.sv ====
// self-checking bench of the four stage shift register
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module bidir_universal_shift_reg4_test;
    import bur_pkg::*;
    logic       clk, srst, clear_n, msl, msh, sl_in, sr_in, stall;
    logic [3:0] par, stg, sdata, last_word, save;
    logic       first_o, last_o, op_ready, svalid, sready;
    logic [7:0] taken_cnt, base;
    int         mismatches, n_compared, n_ops;
    // rows: {high, low, left serial, right serial, parallel, expected stages}
    localparam logic [11:0] ROWS [8] = '{12'hCAA, 12'h505, 12'hA0A, 12'h00A,
                                         12'h805, 12'h40A, 12'hC33, 12'h406};

    bur_shift_reg4 dut (.clk(clk), .srst(srst), .clear_n(clear_n),
        .mode_select_low(msl), .mode_select_high(msh), .serial_left_in(sl_in),
        .serial_right_in(sr_in), .parallel_in(par), .stage_outputs(stg),
        .first_stage_out(first_o), .last_stage_out(last_o), .op_ready(op_ready),
        .snap_valid(svalid), .snap_ready(sready), .snap_data(sdata));
    bur_snap_sink sink (.clk(clk), .srst(srst), .stall(stall), .snap_valid(svalid),
        .snap_data(sdata), .snap_ready(sready), .taken_cnt(taken_cnt), .last_word(last_word));

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #100us;
        mismatches++;
        finish_test();
    end

    initial begin
        {srst, clear_n, msl, msh, sl_in, sr_in, stall, par} = {7'b1100000, 4'h0};
        mismatches = 0;
        n_compared = 0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        // ****************************************************************
        // table of ordinary operations; hold between rows keeps edges idle
        // ****************************************************************
        foreach (ROWS[i]) begin
            @(posedge clk);
            {msh, msl, sl_in, sr_in, par} <= ROWS[i][11:4];
            @(posedge clk);
            {msh, msl} <= 2'h0;
            #1;
            `CHK("stages", ROWS[i][3:0], stg)
            `CHK("first", ROWS[i][0], first_o)
            `CHK("last", ROWS[i][3], last_o)
        end
        repeat (3) @(posedge clk);
        #1;
        `CHK("stages idle", 4'h6, stg)
        `CHK("words", 8'h07, taken_cnt)
        `CHK("last word", 4'h6, last_word)
        // ****************************************************************
        // clear beats a load and acts before any edge
        // ****************************************************************
        @(posedge clk);
        {clear_n, msh, msl, par} <= {3'b011, 4'hF};
        #1;
        `CHK("clear now", 4'h0, stg)
        @(posedge clk);
        {clear_n, msh, msl} <= 3'b100;
        @(posedge clk);
        #1;
        `CHK("clear kept", 4'h0, stg)
        // ****************************************************************
        // fill the fifo with the sink stalled, then check refusal and drain
        // ****************************************************************
        base = taken_cnt;
        n_ops = 0;
        @(posedge clk);
        {msh, msl, stall} <= 3'b011;
        repeat (40) begin
            #1;
            if (op_ready === 1'b1) n_ops++;
            @(posedge clk);
            sr_in <= ~sr_in;
        end
        `CHK("ops taken", 33, n_ops)
        #1;
        save = stg;
        // 33 right shifts from zero with the serial bit toggling from 0
        `CHK("filled stages", 4'hA, stg)
        @(posedge clk);
        #1;
        `CHK("stalled stages", save, stg)
        @(posedge clk);
        {msh, msl, stall} <= 3'b000;
        repeat (100) begin
            @(posedge clk);
            #1;
            if (taken_cnt == base + 8'd33) break;
        end
        #1;
        `CHK("drained", base + 8'd33, taken_cnt)
        `CHK("drained last", 4'hA, last_word)
        // ****************************************************************
        // reset again in mid-run
        // ****************************************************************
        // a loaded word waits in the output register when reset strikes
        @(posedge clk);
        {msh, msl, stall} <= 3'b111;
        @(posedge clk);
        {msh, msl} <= 2'h0;
        @(posedge clk);
        srst <= 1'b1;
        #1;
        `CHK("valid before reset", 1'b1, svalid)
        `CHK("loaded before reset", 4'hF, stg)
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        stall <= 1'b0;
        #1;
        `CHK("reset stages", 4'h0, stg)
        `CHK("reset valid", 1'b0, svalid)
        `CHK("reset ready", 1'b1, op_ready)
        finish_test();
    end
endmodule
`default_nettype wire
